// ### logic/spt_pkg.sv
// Constants shared by the output-three first product term selector
`default_nettype none
package spt_pkg;
  // Register bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // Register offsets
  localparam logic [7:0] OFF_PRIMARY_WD_SEL = 8'h16;
  localparam logic [7:0] OFF_SECONDARY_GPI_SEL = 8'h17;
  localparam logic [7:0] OFF_GPI_OUTPUT_SEL = 8'h18;
  localparam logic [7:0] OFF_OUTPUT8_SEL = 8'h1c;
  localparam logic [7:0] OFF_MANUAL_RESET_MAP = 8'h40;
  localparam logic [7:0] OFF_TERM_STATUS = 8'h50;
  // Reset values
  localparam logic [7:0] RST_PRIMARY_WD_SEL = 8'h00;
  localparam logic [7:0] RST_SECONDARY_GPI_SEL = 8'h00;
  localparam logic [7:0] RST_GPI_OUTPUT_SEL = 8'h00;
  localparam logic [7:0] RST_OUTPUT8_SEL = 8'h00;
  localparam logic [7:0] RST_MANUAL_RESET_MAP = 8'h00;
  localparam logic [7:0] RST_READ_DATA = 8'h00;
  // Field positions
  localparam int BIT_WD_ONE = 6;
  localparam int BIT_WD_TWO = 7;
  localparam int BIT_GPI_ONE = 6;
  localparam int BIT_GPI_TWO = 7;
  localparam int BIT_GPI_THREE = 0;
  localparam int BIT_GPI_FOUR = 1;
  localparam int BIT_OUT_ONE = 2;
  localparam int BIT_OUT_TWO = 3;
  localparam int BIT_OUT_FOUR = 4;
  localparam int BIT_OUT_EIGHT = 0;
  localparam int BIT_MR_OUT_THREE = 2;
  // Status register field positions
  localparam int STAT_PRODUCT_ONE = 0;
  localparam int STAT_PRODUCT_TWO = 1;
  localparam int STAT_OUT_ASSERTED = 2;
  localparam int STAT_MR_LOW = 3;
  // Selection bits that exist on the smaller variant
  localparam logic [7:0] SMALL_MASK_PRIMARY_WD = 8'hcf;
  localparam logic [7:0] SMALL_MASK_SECONDARY_GPI = 8'hcf;
  localparam logic [7:0] SMALL_MASK_GPI_OUTPUT = 8'hf3;
  localparam logic [7:0] SMALL_MASK_OUTPUT8 = 8'h00;
  localparam logic [7:0] FULL_MASK = 8'hff;
  // Width of the combined selection vector
  localparam int TERM_W = 25;
endpackage
`default_nettype wire

// ### logic/spt_and_term.sv
// Product term of selected conditions: AND over every selected good flag
`default_nettype none
module spt_and_term #(
  parameter int WIDTH = 25
) (
  input wire logic [WIDTH-1:0] select_in,
  input wire logic [WIDTH-1:0] good_in,
  output logic term_out
);
  // An unselected condition counts as true, so it drops out of the AND
  assign term_out = &(~select_in | good_in); // [RQ10] [RQ13]
endmodule
`default_nettype wire

// ### logic/spt_out3_select.sv
// First product term selection and assert logic for sequencer output three
//
// Behaviour
// [RQ1] Bits 0-3 of the primary/watchdog select add the primary thresholds of inputs one to four.
// [RQ2] Bits 4-5 of that register add inputs five and six, on the six-input variant only.
// [RQ3] Bits 6-7 of that register add the expiry of watchdog one and watchdog two.
// [RQ4] Bits 0-5 of the secondary/gpi select add the secondary thresholds of inputs one to six; the smaller variant masks off bits 4-5.
// [RQ5] Bits 6-7 of the secondary/gpi select and bits 0-1 of the next add general inputs one to four.
// [RQ6] Bits 2-3 of the gpi/output select add outputs one and two, on the larger variant only.
// [RQ7] Bits 4-7 of the gpi/output select add outputs four to seven.
// [RQ8] Bit 0 of the output-eight select adds output eight, on the larger variant only.
// [RQ9] With bit 2 of the manual reset map set, a low manual reset asserts output three.
// [RQ10] A cleared selection bit takes its condition out of the product term.
// [RQ11] Output three deasserts while either product term is one and is asserted otherwise.
// [RQ12] Software writes zero to selection bits for parts absent on the smaller variant.
// [RQ13] The product term is the AND of all selected conditions, each true in its good state.
// [RQ14] A voltage condition is good above its threshold, a general input while inactive.
// [RQ15] The term and output are re-evaluated every clock from sampled conditions.
//
// The plain strobed port was chosen for this implementation.
`default_nettype none
module spt_out3_select
  import spt_pkg::*;
#(
  parameter bit LARGE_VARIANT = 1'b1
) (
  input wire logic core_clk_in,
  input wire logic reset_n_in,
  input wire logic [spt_pkg::ADDR_W-1:0] reg_addr_in,
  input wire logic [spt_pkg::DATA_W-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [spt_pkg::DATA_W-1:0] reg_rdata_out,
  input wire logic [5:0] primary_ok_in,
  input wire logic [5:0] secondary_ok_in,
  input wire logic watchdog_one_expired_in,
  input wire logic watchdog_two_expired_in,
  input wire logic [3:0] general_input_active_in,
  input wire logic [7:0] seq_output_asserted_in,
  input wire logic manual_reset_n_in,
  input wire logic product_two_in,
  output logic product_one_out,
  output logic seq_output_three_assert_out
);
  import spt_pkg::*;

  typedef struct packed {
    logic [7:0] sel_primary_wd;
    logic [7:0] sel_secondary_gpi;
    logic [7:0] sel_gpi_output;
    logic [7:0] sel_output8;
    logic [7:0] mr_map;
    logic [7:0] rdata;
    logic product_one;
    logic product_two;
    logic mr_low;
    logic out_asserted;
  } spt_state_t;

  // Bits that exist on the chosen variant; absent ones never take part
  localparam logic [7:0] MASK_PRIMARY_WD = LARGE_VARIANT ? FULL_MASK : SMALL_MASK_PRIMARY_WD;
  localparam logic [7:0] MASK_SECONDARY_GPI =
    LARGE_VARIANT ? FULL_MASK : SMALL_MASK_SECONDARY_GPI;
  localparam logic [7:0] MASK_GPI_OUTPUT = LARGE_VARIANT ? FULL_MASK : SMALL_MASK_GPI_OUTPUT;
  localparam logic [7:0] MASK_OUTPUT8 = LARGE_VARIANT ? FULL_MASK : SMALL_MASK_OUTPUT8;

  spt_state_t st;
  spt_state_t next_st;
  logic [TERM_W-1:0] term_select;
  logic [TERM_W-1:0] term_good;
  logic term_now;
  logic mr_hit;
  logic [7:0] good_primary_wd;
  logic [7:0] good_secondary_gpi;
  logic [7:0] good_gpi_output;

  // Good state of each condition, laid out as its selection bit
  always_comb begin
    good_primary_wd = {~watchdog_two_expired_in, ~watchdog_one_expired_in,
                       primary_ok_in}; // [RQ1] [RQ2] [RQ3] [RQ14]
    good_secondary_gpi = {~general_input_active_in[1], ~general_input_active_in[0],
                          secondary_ok_in}; // [RQ4] [RQ5] [RQ14]
    good_gpi_output = {~seq_output_asserted_in[6:3], ~seq_output_asserted_in[1:0],
                       ~general_input_active_in[3:2]}; // [RQ5] [RQ6] [RQ7]
  end

  // Masking keeps a stray bit from reaching absent hardware on the small part
  assign term_select = {st.sel_output8[BIT_OUT_EIGHT] & MASK_OUTPUT8[BIT_OUT_EIGHT],
                        st.sel_gpi_output & MASK_GPI_OUTPUT,
                        st.sel_secondary_gpi & MASK_SECONDARY_GPI,
                        st.sel_primary_wd & MASK_PRIMARY_WD}; // [RQ2] [RQ6] [RQ8] [RQ12]
  assign term_good = {~seq_output_asserted_in[7], good_gpi_output,
                      good_secondary_gpi, good_primary_wd}; // [RQ8]

  spt_and_term #(
    .WIDTH(TERM_W)
  ) u_term (
    .select_in(term_select),
    .good_in(term_good),
    .term_out(term_now)
  );

  // Manual reset overrides both terms when mapped to this output
  assign mr_hit = st.mr_map[BIT_MR_OUT_THREE] & ~manual_reset_n_in; // [RQ9]

  // Next state: register writes, read data, and the per-cycle evaluation
  always_comb begin
    next_st = st;
    next_st.rdata = RST_READ_DATA;
    if (reg_write_in) begin
      if (reg_addr_in == OFF_PRIMARY_WD_SEL) begin
        next_st.sel_primary_wd = reg_wdata_in;
      end else if (reg_addr_in == OFF_SECONDARY_GPI_SEL) begin
        next_st.sel_secondary_gpi = reg_wdata_in;
      end else if (reg_addr_in == OFF_GPI_OUTPUT_SEL) begin
        next_st.sel_gpi_output = reg_wdata_in;
      end else if (reg_addr_in == OFF_OUTPUT8_SEL) begin
        next_st.sel_output8 = reg_wdata_in;
      end else if (reg_addr_in == OFF_MANUAL_RESET_MAP) begin
        next_st.mr_map = reg_wdata_in;
      end
    end
    // Unmapped reads answer zero
    if (reg_read_in) begin
      if (reg_addr_in == OFF_PRIMARY_WD_SEL) begin
        next_st.rdata = st.sel_primary_wd;
      end else if (reg_addr_in == OFF_SECONDARY_GPI_SEL) begin
        next_st.rdata = st.sel_secondary_gpi;
      end else if (reg_addr_in == OFF_GPI_OUTPUT_SEL) begin
        next_st.rdata = st.sel_gpi_output;
      end else if (reg_addr_in == OFF_OUTPUT8_SEL) begin
        next_st.rdata = st.sel_output8;
      end else if (reg_addr_in == OFF_MANUAL_RESET_MAP) begin
        next_st.rdata = st.mr_map;
      end else if (reg_addr_in == OFF_TERM_STATUS) begin
        next_st.rdata = '0;
        next_st.rdata[STAT_PRODUCT_ONE] = st.product_one;
        next_st.rdata[STAT_PRODUCT_TWO] = st.product_two;
        next_st.rdata[STAT_OUT_ASSERTED] = st.out_asserted;
        next_st.rdata[STAT_MR_LOW] = st.mr_low;
      end
    end
    // Sampled every clock so a change shows one edge later
    next_st.product_one = term_now; // [RQ13] [RQ15]
    next_st.product_two = product_two_in;
    next_st.mr_low = ~manual_reset_n_in;
    next_st.out_asserted = mr_hit | ~(term_now | product_two_in); // [RQ9] [RQ11] [RQ15]
  end

  // Reset puts the output asserted, the safe state for a supervisor
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      st.sel_primary_wd <= RST_PRIMARY_WD_SEL;
      st.sel_secondary_gpi <= RST_SECONDARY_GPI_SEL;
      st.sel_gpi_output <= RST_GPI_OUTPUT_SEL;
      st.sel_output8 <= RST_OUTPUT8_SEL;
      st.mr_map <= RST_MANUAL_RESET_MAP;
      st.rdata <= RST_READ_DATA;
      st.product_one <= 1'b0;
      st.product_two <= 1'b0;
      st.mr_low <= 1'b0;
      st.out_asserted <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata_out = st.rdata;
  assign product_one_out = st.product_one;
  assign seq_output_three_assert_out = st.out_asserted;

  // Checks on the evaluation and the register port
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_mr_mapped_low;
    st.mr_map[BIT_MR_OUT_THREE] && !manual_reset_n_in;
  endsequence

  sequence s_no_mr;
    !(st.mr_map[BIT_MR_OUT_THREE] && !manual_reset_n_in);
  endsequence

  a_primary_one_fail: assert property ( // [RQ1] [RQ14]
    st.sel_primary_wd[0] && !primary_ok_in[0] |=> !product_one_out)
    else $error("selected primary threshold low but term true");

  a_watchdog_one_fail: assert property ( // [RQ3]
    st.sel_primary_wd[BIT_WD_ONE] && watchdog_one_expired_in |=> !product_one_out)
    else $error("selected watchdog expired but term true");

  a_secondary_fail: assert property ( // [RQ4]
    st.sel_secondary_gpi[0] && !secondary_ok_in[0] |=> !product_one_out)
    else $error("selected secondary threshold bad but term true");

  a_gpi_one_fail: assert property ( // [RQ5] [RQ14]
    st.sel_secondary_gpi[BIT_GPI_ONE] && general_input_active_in[0] |=> !product_one_out)
    else $error("selected general input active but term true");

  a_output_four_fail: assert property ( // [RQ7]
    st.sel_gpi_output[BIT_OUT_FOUR] && seq_output_asserted_in[3] |=> !product_one_out)
    else $error("selected output four asserted but term true");

  a_empty_term_true: assert property ( // [RQ10] [RQ13]
    term_select == '0 |=> product_one_out)
    else $error("term false with nothing selected");

  a_mr_asserts_out: assert property ( // [RQ9]
    s_mr_mapped_low |=> seq_output_three_assert_out)
    else $error("mapped manual reset low but output not asserted");

  a_term_deasserts: assert property ( // [RQ11]
    s_no_mr ##0 (term_now || product_two_in) |=> !seq_output_three_assert_out)
    else $error("a product term true but output asserted");

  a_both_false_assert: assert property ( // [RQ11] [RQ15]
    !term_now && !product_two_in |=> seq_output_three_assert_out && !product_one_out)
    else $error("both terms false but output deasserted");

  a_read_back: assert property (
    reg_write_in && reg_addr_in == OFF_PRIMARY_WD_SEL ##1
    reg_read_in && reg_addr_in == OFF_PRIMARY_WD_SEL && !reg_write_in
    |=> reg_rdata_out == $past(reg_wdata_in, 2))
    else $error("select register read back differs from write");

  a_read_idle_zero: assert property (
    !reg_read_in |=> reg_rdata_out == 8'h00)
    else $error("read data not zero outside read answer");

  a_primary_four_fail: assert property ( // [RQ1] [RQ14]
    st.sel_primary_wd[3] && !primary_ok_in[3] |=> !product_one_out)
    else $error("selected primary threshold four low but term true");

  a_primary_five_fail: assert property ( // [RQ2]
    LARGE_VARIANT && st.sel_primary_wd[4] && !primary_ok_in[4] |=> !product_one_out)
    else $error("selected primary threshold five low but term true");

  a_primary_six_fail: assert property ( // [RQ2]
    LARGE_VARIANT && st.sel_primary_wd[5] && !primary_ok_in[5] |=> !product_one_out)
    else $error("selected primary threshold six low but term true");

  a_watchdog_two_fail: assert property ( // [RQ3]
    st.sel_primary_wd[BIT_WD_TWO] && watchdog_two_expired_in |=> !product_one_out)
    else $error("selected watchdog two expired but term true");

  a_secondary_six_fail: assert property ( // [RQ4]
    st.sel_secondary_gpi[5] && !secondary_ok_in[5] |=> !product_one_out)
    else $error("selected secondary threshold six bad but term true");

  a_gpi_two_fail: assert property ( // [RQ5] [RQ14]
    st.sel_secondary_gpi[BIT_GPI_TWO] && general_input_active_in[1] |=> !product_one_out)
    else $error("selected general input two active but term true");

  a_gpi_three_fail: assert property ( // [RQ5] [RQ14]
    st.sel_gpi_output[BIT_GPI_THREE] && general_input_active_in[2] |=> !product_one_out)
    else $error("selected general input three active but term true");

  a_gpi_four_fail: assert property ( // [RQ5] [RQ14]
    st.sel_gpi_output[BIT_GPI_FOUR] && general_input_active_in[3] |=> !product_one_out)
    else $error("selected general input four active but term true");

  a_output_one_fail: assert property ( // [RQ6]
    LARGE_VARIANT && st.sel_gpi_output[BIT_OUT_ONE] && seq_output_asserted_in[0]
    |=> !product_one_out)
    else $error("selected output one asserted but term true");

  a_output_two_fail: assert property ( // [RQ6]
    LARGE_VARIANT && st.sel_gpi_output[BIT_OUT_TWO] && seq_output_asserted_in[1]
    |=> !product_one_out)
    else $error("selected output two asserted but term true");

  a_output_seven_fail: assert property ( // [RQ7]
    st.sel_gpi_output[7] && seq_output_asserted_in[6] |=> !product_one_out)
    else $error("selected output seven asserted but term true");

  a_output_eight_fail: assert property ( // [RQ8]
    LARGE_VARIANT && st.sel_output8[BIT_OUT_EIGHT] && seq_output_asserted_in[7]
    |=> !product_one_out)
    else $error("selected output eight asserted but term true");

  a_all_good_true: assert property ( // [RQ13]
    term_good == '1 |=> product_one_out)
    else $error("every condition good but term false");

  a_unmapped_mr_quiet: assert property ( // [RQ9]
    !st.mr_map[BIT_MR_OUT_THREE] && !manual_reset_n_in && term_now
    |=> !seq_output_three_assert_out)
    else $error("unmapped manual reset asserted output three");

  a_mr_low_status: assert property ( // [RQ15]
    !manual_reset_n_in |=> st.mr_low)
    else $error("manual reset low not sampled");

  a_product_two_sampled: assert property ( // [RQ15]
    product_two_in |=> st.product_two)
    else $error("second product term not sampled");

  a_read_gpi_output: assert property (
    reg_read_in && reg_addr_in == OFF_GPI_OUTPUT_SEL
    |=> reg_rdata_out == $past(st.sel_gpi_output))
    else $error("gpi and output select read differs from register");

  a_status_read: assert property ( // [RQ11]
    reg_read_in && reg_addr_in == OFF_TERM_STATUS
    |=> reg_rdata_out[STAT_OUT_ASSERTED] == $past(st.out_asserted))
    else $error("status read differs from output state");
endmodule
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench for the output-three first product term selector
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import spt_pkg::*;
  logic core_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic reg_write_in = 1'b0;
  logic reg_read_in = 1'b0;
  logic [7:0] reg_rdata_out;
  logic [5:0] primary_ok_in = 6'h3f;
  logic [5:0] secondary_ok_in = 6'h3f;
  logic watchdog_one_expired_in = 1'b0;
  logic watchdog_two_expired_in = 1'b0;
  logic [3:0] general_input_active_in = 4'h0;
  logic [7:0] seq_output_asserted_in = 8'h00;
  logic manual_reset_n_in = 1'b1;
  logic product_two_in = 1'b0;
  logic product_one_out;
  logic seq_output_three_assert_out;
  int n_mismatch = 0;
  int n_checks = 0;
  int cycles = 0;
  localparam logic [24:0] ALL = 25'h1ffffff;
  localparam bit VARIANT_LARGE = 1'b1;

  spt_out3_select #(.LARGE_VARIANT(VARIANT_LARGE)) uut (.core_clk_in(core_clk_in),
    .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .primary_ok_in(primary_ok_in), .secondary_ok_in(secondary_ok_in),
    .watchdog_one_expired_in(watchdog_one_expired_in),
    .watchdog_two_expired_in(watchdog_two_expired_in),
    .general_input_active_in(general_input_active_in),
    .seq_output_asserted_in(seq_output_asserted_in), .manual_reset_n_in(manual_reset_n_in),
    .product_two_in(product_two_in), .product_one_out(product_one_out),
    .seq_output_three_assert_out(seq_output_three_assert_out));

  // 100 MHz clock
  always #5 core_clk_in = ~core_clk_in;

  // Hang guard; the full run needs well under a thousand cycles
  always @(posedge core_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic final_report();
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge core_clk_in);
    reg_write_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge core_clk_in);
    reg_read_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  // Write then read with no gap between the strobes
  task automatic wr_rd(input logic [7:0] a, input logic [7:0] w, output logic [7:0] d);
    @(posedge core_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= w;
    reg_write_in <= 1'b1;
    @(posedge core_clk_in);
    reg_write_in <= 1'b0;
    reg_read_in <= 1'b1;
    @(posedge core_clk_in);
    reg_read_in <= 1'b0;
    #1 d = reg_rdata_out;
  endtask

  // Bits absent on the small part are written as zero there
  task automatic set_sel(input logic [24:0] s);
    wr(OFF_PRIMARY_WD_SEL, s[7:0] & (VARIANT_LARGE ? FULL_MASK : SMALL_MASK_PRIMARY_WD));
    wr(OFF_SECONDARY_GPI_SEL,
       s[15:8] & (VARIANT_LARGE ? FULL_MASK : SMALL_MASK_SECONDARY_GPI));
    wr(OFF_GPI_OUTPUT_SEL, s[23:16] & (VARIANT_LARGE ? FULL_MASK : SMALL_MASK_GPI_OUTPUT));
    wr(OFF_OUTPUT8_SEL, {7'h00, s[24] & VARIANT_LARGE});
  endtask

  // Drive conditions from a good-state vector laid out like the select vector;
  // output three's own bit gets a changing value it must ignore
  task automatic drive(input logic [24:0] g, input logic p2);
    @(posedge core_clk_in);
    primary_ok_in <= g[5:0];
    watchdog_one_expired_in <= ~g[6];
    watchdog_two_expired_in <= ~g[7];
    secondary_ok_in <= g[13:8];
    general_input_active_in <= ~g[17:14];
    seq_output_asserted_in <= {~g[24:20], g[0], ~g[19:18]};
    product_two_in <= p2;
    @(posedge core_clk_in);
    #1;
  endtask

  task automatic expect_out(input logic [24:0] s, input logic [24:0] g, input logic p2,
                            input logic mr_on);
    logic p1;
    p1 = &(g | ~s);
    chk("product_one_out", {7'h00, p1}, {7'h00, product_one_out});
    chk("assert_out", {7'h00, mr_on | ~(p1 | p2)}, {7'h00, seq_output_three_assert_out});
  endtask

  task automatic t_registers();
    logic [7:0] d;
    logic [7:0] offs [5] = '{OFF_PRIMARY_WD_SEL, OFF_SECONDARY_GPI_SEL, OFF_GPI_OUTPUT_SEL,
                             OFF_OUTPUT8_SEL, OFF_MANUAL_RESET_MAP};
    for (int i = 0; i < 5; i++) begin
      rd(offs[i], d);
      chk("reset value", 8'h00, d);
      wr(offs[i], 8'ha5 ^ 8'(i));
      rd(offs[i], d);
      chk("read back", 8'ha5 ^ 8'(i), d);
    end
    @(posedge core_clk_in);
    #1 chk("rdata after read", 8'h00, reg_rdata_out);
    wr(8'h33, 8'hff);
    rd(8'h33, d);
    chk("unmapped read", 8'h00, d);
    rd(OFF_PRIMARY_WD_SEL, d);
    chk("after unmapped write", 8'ha5, d);
    wr_rd(OFF_PRIMARY_WD_SEL, 8'h5a, d);
    chk("back to back read", 8'h5a, d);
    set_sel(25'h0);
    wr(OFF_MANUAL_RESET_MAP, 8'h00);
    // Status is read-only; empty term is true, so output three is released
    wr(OFF_TERM_STATUS, 8'hf0);
    drive(ALL, 1'b1);
    rd(OFF_TERM_STATUS, d);
    chk("status", 8'h03, d);
    expect_out(25'h0, 25'h0, 1'b0, 1'b0);
  endtask

  // One select bit at a time: selected condition bad, then only it good
  task automatic t_each_select();
    logic [24:0] s;
    for (int k = 0; k < TERM_W; k++) begin
      s = 25'h1 << k;
      set_sel(s);
      drive(~s, 1'b0);
      expect_out(s, ~s, 1'b0, 1'b0);
      drive(s, 1'b0);
      expect_out(s, s, 1'b0, 1'b0);
    end
  endtask

  task automatic t_sum_and_mr();
    set_sel(ALL);
    drive(ALL, 1'b0);
    expect_out(ALL, ALL, 1'b0, 1'b0);
    drive(25'h1ffdfff, 1'b0);
    expect_out(ALL, 25'h1ffdfff, 1'b0, 1'b0);
    drive(25'h1ffdfff, 1'b1);
    expect_out(ALL, 25'h1ffdfff, 1'b1, 1'b0);
    // Other map bits must not route the manual reset here
    wr(OFF_MANUAL_RESET_MAP, 8'hfb);
    @(posedge core_clk_in);
    manual_reset_n_in <= 1'b0;
    drive(ALL, 1'b0);
    expect_out(ALL, ALL, 1'b0, 1'b0);
    wr(OFF_MANUAL_RESET_MAP, 8'h04);
    drive(ALL, 1'b1);
    expect_out(ALL, ALL, 1'b1, 1'b1);
    @(posedge core_clk_in);
    manual_reset_n_in <= 1'b1;
    drive(ALL, 1'b0);
    expect_out(ALL, ALL, 1'b0, 1'b0);
  endtask

  initial begin
    repeat (5) @(posedge core_clk_in);
    #1 chk("product_one_out in reset", 8'h00, {7'h00, product_one_out});
    chk("assert_out in reset", 8'h01, {7'h00, seq_output_three_assert_out});
    @(posedge core_clk_in);
    reset_n_in <= 1'b1;
    t_registers();
    t_each_select();
    t_sum_and_mr();
    final_report();
  end
endmodule
`default_nettype wire
